// >>> hdl/loss_of_signal_status.v
// Purpose: per-channel loss-of-signal detection with alarm status registers
// Assumes: one clock; line inputs synchronous to aclk; AXI4-Lite slave
// Notes:   one read-only line_alarm_status word per channel
//
// Contract
// - digital declares after 160 pulseless bits
// - digital clears at 33 percent density
// - bit 5 shows digital detector state
// - bit 4 shows analog detector state
// - analog declares below declare threshold
// - analog clears only above clear threshold
// - channel state is analog OR digital
// - bit 1 shows combined channel state
// - E3 mode uses E3 detector instead
`timescale 1ns/1ps
`include "los_defines.vh"

module loss_of_signal_status #(
  parameter        CHANNELS = 12,
  parameter        ADDR_W   = 8,
  parameter [15:0] RUN_BITS = `LOS_RUN_BITS,
  parameter        DENS_WIN = `LOS_DENS_WIN
) (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire [ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]          s_axi_awprot,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]          s_axi_arprot,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  input  wire [CHANNELS-1:0] bit_en,
  input  wire [CHANNELS-1:0] line_pulse,
  input  wire [CHANNELS-1:0] amp_below_declare,
  input  wire [CHANNELS-1:0] amp_above_clear,
  input  wire [CHANNELS-1:0] e3_los_in,
  output reg  [CHANNELS-1:0] los_state,
  output reg                 irq
);

  // ---------------------------------------------------------------
  // derived constants
  // ---------------------------------------------------------------
  // least number of ones in the window that meets the density
  localparam        MIN_INT  = (`LOS_DENS_PCT * DENS_WIN + 99) / 100;
  localparam [15:0] MIN_ONES = MIN_INT[15:0];
  localparam        TOP_INT  = `LOS_OFF_ALARM0 + 4 * CHANNELS;
  localparam [ADDR_W-1:0] ALARM_TOP = TOP_INT[ADDR_W-1:0];
  localparam [ADDR_W-1:0] A_CTRL    = `LOS_OFF_CTRL;
  localparam [ADDR_W-1:0] A_STAT    = `LOS_OFF_IRQ_STAT;
  localparam [ADDR_W-1:0] A_MASK    = `LOS_OFF_IRQ_MASK;
  localparam [ADDR_W-1:0] A_ALARM0  = `LOS_OFF_ALARM0;
  localparam [31:0]       RST_CTRL  = `LOS_RST_CTRL;
  localparam [31:0]       RST_MASK  = `LOS_RST_MASK;

  // ---------------------------------------------------------------
  // software-visible state
  // ---------------------------------------------------------------
  reg  [CHANNELS-1:0]   e3_mode;
  reg  [CHANNELS-1:0]   irq_mask;
  reg  [CHANNELS-1:0]   irq_status;
  reg  [CHANNELS-1:0]   next_irq_status;
  wire [CHANNELS-1:0]   dig_los;
  wire [CHANNELS-1:0]   ana_los;
  wire [CHANNELS-1:0]   next_los;
  wire [8*CHANNELS-1:0] alarm_flat;

  // ---------------------------------------------------------------
  // per-channel detectors
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      digital_los_detector #(
        .RUN_BITS (RUN_BITS),
        .WIN      (DENS_WIN),
        .MIN_ONES (MIN_ONES)
      ) u_dig (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bit_en  (bit_en[i]),
        .pulse   (line_pulse[i]),
        .los     (dig_los[i])
      );

      analog_los_tracker u_ana (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .below_declare (amp_below_declare[i]),
        .above_clear   (amp_above_clear[i]),
        .los           (ana_los[i])
      );

      assign next_los[i] = e3_mode[i] ? e3_los_in[i] : (dig_los[i] | ana_los[i]);

      assign alarm_flat[8*i+7:8*i] = {2'h0, dig_los[i], ana_los[i], 2'h0, los_state[i], 1'b0};
    end
  endgenerate

  // ---------------------------------------------------------------
  // combined state and change events
  // ---------------------------------------------------------------
  wire [CHANNELS-1:0] los_change = next_los ^ los_state;

  always @(posedge aclk) begin
    if (!aresetn)
      los_state <= {CHANNELS{1'b0}};
    else
      los_state <= next_los;
  end

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  reg  [ADDR_W-1:0] wr_addr;
  reg  [31:0]       wr_data;
  reg  [3:0]        wr_strb;
  reg               aw_held;
  reg               w_held;
  wire              wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0]       wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0]       ctrl_word = {{(32-CHANNELS){1'b0}}, e3_mode};
  wire [31:0]       mask_word = {{(32-CHANNELS){1'b0}}, irq_mask};
  wire [31:0]       ctrl_new = (ctrl_word & ~wr_mask) | (wr_data & wr_mask);
  wire [31:0]       mask_new = (mask_word & ~wr_mask) | (wr_data & wr_mask);
  wire              wr_alarm = (wr_addr >= A_ALARM0) && (wr_addr < ALARM_TOP);
  wire              wr_known = (wr_addr[ADDR_W-1:2] == A_CTRL[ADDR_W-1:2]) ||
                               (wr_addr[ADDR_W-1:2] == A_STAT[ADDR_W-1:2]) ||
                               (wr_addr[ADDR_W-1:2] == A_MASK[ADDR_W-1:2]) || wr_alarm;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LOS_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= {ADDR_W{1'b0}};
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      e3_mode       <= RST_CTRL[CHANNELS-1:0];
      irq_mask      <= RST_MASK[CHANNELS-1:0];
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `LOS_RESP_OKAY : `LOS_RESP_SLVERR;
        // status words are read-only; writes there are dropped
        if (wr_addr[ADDR_W-1:2] == A_CTRL[ADDR_W-1:2])
          e3_mode <= ctrl_new[CHANNELS-1:0];
        if (wr_addr[ADDR_W-1:2] == A_MASK[ADDR_W-1:2])
          irq_mask <= mask_new[CHANNELS-1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  reg  [31:0]       rd_word;
  reg               rd_known;
  reg  [ADDR_W-1:0] rd_off;
  integer           c;
  wire              rd_take = s_axi_arvalid & s_axi_arready;
  wire              rd_stat = rd_take && (s_axi_araddr[ADDR_W-1:2] == A_STAT[ADDR_W-1:2]);

  always @* begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    rd_off   = s_axi_araddr - A_ALARM0;
    if (s_axi_araddr[ADDR_W-1:2] == A_CTRL[ADDR_W-1:2]) begin
      rd_word = ctrl_word;
    end else if (s_axi_araddr[ADDR_W-1:2] == A_STAT[ADDR_W-1:2]) begin
      rd_word = {{(32-CHANNELS){1'b0}}, irq_status};
    end else if (s_axi_araddr[ADDR_W-1:2] == A_MASK[ADDR_W-1:2]) begin
      rd_word = mask_word;
    end else if ((s_axi_araddr >= A_ALARM0) && (s_axi_araddr < ALARM_TOP)) begin
      for (c = 0; c < CHANNELS; c = c + 1) begin
        if (rd_off[ADDR_W-1:2] == c[ADDR_W-3:0])
          rd_word = {24'h00_0000, alarm_flat[8*c+:8]};
      end
    end else begin
      rd_known = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LOS_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_known ? `LOS_RESP_OKAY : `LOS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  // a change in the same cycle as the clearing read stays set,
  // so no edge of the channel state is ever lost
  always @* begin
    next_irq_status = irq_status;
    if (rd_stat)
      next_irq_status = {CHANNELS{1'b0}};
    next_irq_status = next_irq_status | los_change;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= {CHANNELS{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// >>> inc/los_defines.vh
// Purpose: constants shared by the loss-of-signal status block
// Assumes: byte addresses on a 32-bit register bus
// Notes:   definitions only
`ifndef LOS_DEFINES_VH
`define LOS_DEFINES_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define LOS_OFF_CTRL      8'h00
`define LOS_OFF_IRQ_STAT  8'h04
`define LOS_OFF_IRQ_MASK  8'h08
`define LOS_OFF_ALARM0    8'h10

// ---------------------------------------------------------------
// line_alarm_status field positions
// ---------------------------------------------------------------
`define LOS_BIT_DIGITAL   5
`define LOS_BIT_ANALOG    4
`define LOS_BIT_COMBINED  1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LOS_RST_CTRL      32'h0000_0000
`define LOS_RST_MASK      32'h0000_0000

// ---------------------------------------------------------------
// detector figures
// ---------------------------------------------------------------
// 160 bit periods without a pulse
`define LOS_RUN_BITS      16'h00A0
// clear at 33 percent pulse density
`define LOS_DENS_PCT      33
// sliding density window, bit periods
`define LOS_DENS_WIN      32

// ---------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------
`define LOS_RESP_OKAY     2'h0
`define LOS_RESP_SLVERR   2'h2

`endif

// >>> hdl/digital_los_detector.v
// Purpose: digital loss-of-signal detector for one channel
// Assumes: bit_en marks one recovered bit period, pulse is its value
// Notes:   declares on a run of empty bits, clears on pulse density
`timescale 1ns/1ps
`include "los_defines.vh"

module digital_los_detector #(
  parameter [15:0] RUN_BITS = `LOS_RUN_BITS,
  parameter        WIN      = `LOS_DENS_WIN,
  parameter [15:0] MIN_ONES = 16'h000B
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire bit_en,
  input  wire pulse,
  output wire los
);

  localparam [1:0] ST_CLEAR    = 2'b01;
  localparam [1:0] ST_DECLARED = 2'b10;

  reg  [1:0]     state;
  reg  [1:0]     next_state;
  reg  [15:0]    run_cnt;
  reg  [15:0]    next_run;
  reg  [WIN-1:0] window;
  reg  [15:0]    ones;
  reg  [15:0]    next_ones;

  assign los = state[1];

  always @* begin
    next_run   = run_cnt;
    next_ones  = ones;
    next_state = state;
    if (bit_en) begin
      next_ones = ones + {15'h0000, pulse} - {15'h0000, window[WIN-1]};
      if (pulse)
        next_run = 16'h0000;
      else if (run_cnt != RUN_BITS)
        next_run = run_cnt + 16'h0001;
      case (state)
        ST_CLEAR: begin
          if (next_run == RUN_BITS)
            next_state = ST_DECLARED;
        end
        ST_DECLARED: begin
          if (next_ones >= MIN_ONES)
            next_state = ST_CLEAR;
        end
        default: next_state = ST_CLEAR;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_CLEAR;
      run_cnt <= 16'h0000;
      window  <= {WIN{1'b0}};
      ones    <= 16'h0000;
    end else begin
      state   <= next_state;
      run_cnt <= next_run;
      ones    <= next_ones;
      if (bit_en)
        window <= {window[WIN-2:0], pulse};
    end
  end

endmodule

// >>> hdl/analog_los_tracker.v
// Purpose: hysteresis latch for the analog loss-of-signal indication
// Assumes: front end flags amplitude below declare / above clear level
// Notes:   between the two thresholds the state holds
`timescale 1ns/1ps

module analog_los_tracker (
  input  wire aclk,
  input  wire aresetn,
  input  wire below_declare,
  input  wire above_clear,
  output reg  los
);

  always @(posedge aclk) begin
    if (!aresetn) begin
      los <= 1'b0;
    end else if (below_declare) begin
      los <= 1'b1;
    end else if (above_clear) begin
      los <= 1'b0;
    end
  end

endmodule

// >>> dv/los_status_sva.sv
// Purpose: port checks for loss_of_signal_status
// Assumes: channel 0 carries the line checks
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module los_status_sva #(
  parameter CHANNELS = 2
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [CHANNELS-1:0] amp_below_declare,
  input wire logic [CHANNELS-1:0] e3_los_in,
  input wire logic [CHANNELS-1:0] los_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_wr_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  a_los_or_declare: assert property ((amp_below_declare[0] && e3_los_in[0])[*3] |-> los_state[0])
    else $error("channel state missed a declare");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($rose(los_state[0]));
endmodule

bind loss_of_signal_status los_status_sva #(.CHANNELS(CHANNELS)) los_status_sva_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .amp_below_declare, .e3_los_in, .los_state);

// >>> dv/line_front_end.sv
// Purpose: receiver front end model feeding recovered bits and amplitude flags
// Assumes: one recovered bit every other clock
// Notes:   pulse line is scrambled between bits
`timescale 1ns/1ps
module line_front_end #(
  parameter CHANNELS = 2
) (
  input  wire logic          aclk,
  output logic [CHANNELS-1:0] bit_en,
  output logic [CHANNELS-1:0] line_pulse,
  output logic [CHANNELS-1:0] amp_below_declare,
  output logic [CHANNELS-1:0] amp_above_clear
);
  initial begin
    bit_en = '0;
    line_pulse = '0;
    amp_below_declare = '0;
    amp_above_clear = '1;
  end
  // n bits, a pulse on every k-th bit, k = 0 sends none
  task automatic send_bits(input int ch, input int n, input int k);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      bit_en[ch] <= 1'b1;
      line_pulse[ch] <= (k != 0) && (i % k == 0);
      @(posedge aclk);
      bit_en[ch] <= 1'b0;
      // no stale value between bits: a detector must not look here
      line_pulse[ch] <= ~line_pulse[ch];
    end
  endtask
  task automatic set_amp(input int ch, input logic below, input logic above);
    @(posedge aclk);
    amp_below_declare[ch] <= below;
    amp_above_clear[ch] <= above;
  endtask
endmodule

// >>> dv/loss_of_signal_status_tb_top.sv
// Purpose: self-checking bench for loss_of_signal_status
// Assumes: two channels, AXI4-Lite master tasks
// Notes:   line stimulus comes from line_front_end
`timescale 1ns/1ps
module loss_of_signal_status_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic bvalid, awready, wready, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rrs;
  logic [1:0] e3_los_in, los_state, bit_en, line_pulse, below, above;
  int n_fail = 0;
  int cmp_count = 0;

  loss_of_signal_status #(.CHANNELS(2)) loss_of_signal_status_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bit_en(bit_en),
    .line_pulse(line_pulse), .amp_below_declare(below), .amp_above_clear(above),
    .e3_los_in(e3_los_in), .los_state(los_state), .irq(irq));
  line_front_end #(.CHANNELS(2)) line_front_end_inst (.aclk(aclk), .bit_en(bit_en),
    .line_pulse(line_pulse), .amp_below_declare(below), .amp_above_clear(above));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (t == 50) begin n_fail++; complete_run(); end
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdv = rdata; rrs = rresp;
    rready <= 1'b0;
    if (t == 50) begin n_fail++; complete_run(); end
  endtask

  task automatic t_reset_values;
    axi_rd(8'h00); chk(rdv, 32'h0);
    axi_rd(8'h08); chk(rdv, 32'h0);
    axi_rd(8'h10); chk(rdv, 32'h0);
    axi_rd(8'h0C); chk(rdv, 32'h0);
    chk({30'h0, rrs}, 32'h2);
    axi_wr(8'h0C, 32'h1, 2'h2);
    axi_wr(8'h10, 32'hFF, 2'h0);
    axi_rd(8'h10); chk(rdv, 32'h0);
    $display("reset and map test done");
  endtask
  task automatic t_digital;
    line_front_end_inst.send_bits(0, 159, 0);
    idle(4);
    axi_rd(8'h10); chk(rdv, 32'h0);
    line_front_end_inst.send_bits(0, 1, 0);
    idle(4);
    axi_rd(8'h10); chk(rdv, 32'h22);
    line_front_end_inst.send_bits(0, 64, 4);
    idle(4);
    axi_rd(8'h10); chk(rdv, 32'h22);
    line_front_end_inst.send_bits(0, 32, 2);
    idle(4);
    axi_rd(8'h10); chk(rdv, 32'h0);
    $display("digital detector test done");
  endtask
  task automatic t_analog_irq;
    axi_wr(8'h08, 32'h1, 2'h0);
    axi_rd(8'h04);
    // external indication must be ignored outside E3 mode
    e3_los_in[0] <= 1'b1;
    line_front_end_inst.set_amp(0, 1'b1, 1'b0);
    idle(4);
    chk({31'h0, irq}, 32'h1);
    axi_rd(8'h10); chk(rdv, 32'h12);
    axi_rd(8'h04); chk(rdv, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    line_front_end_inst.set_amp(0, 1'b0, 1'b0);
    idle(8);
    axi_rd(8'h10); chk(rdv, 32'h12);
    axi_wr(8'h08, 32'h0, 2'h0);
    line_front_end_inst.set_amp(0, 1'b0, 1'b1);
    idle(4);
    chk({31'h0, irq}, 32'h0);
    axi_rd(8'h10); chk(rdv, 32'h0);
    axi_rd(8'h04); chk(rdv, 32'h1);
    e3_los_in[0] <= 1'b0;
    $display("analog and interrupt test done");
  endtask
  task automatic t_e3_mode;
    axi_wr(8'h00, 32'h2, 2'h0);
    axi_rd(8'h00); chk(rdv, 32'h2);
    e3_los_in[1] <= 1'b1;
    idle(4);
    chk({30'h0, los_state}, 32'h2);
    axi_rd(8'h14); chk(rdv, 32'h2);
    e3_los_in[1] <= 1'b0;
    line_front_end_inst.set_amp(1, 1'b1, 1'b0);
    idle(4);
    axi_rd(8'h14); chk(rdv, 32'h10);
    line_front_end_inst.set_amp(1, 1'b0, 1'b1);
    axi_wr(8'h00, 32'h0, 2'h0);
    $display("e3 mode test done");
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; e3_los_in = 2'h0;
    idle(8);
    aresetn <= 1'b1;
    idle(2);
    t_reset_values();
    t_digital();
    t_analog_irq();
    t_e3_mode();
    complete_run();
  end
endmodule
